// >>> core/aha_pkg.sv
// package: constants and types of the alarm horn and acknowledge block
package aha_pkg;

  // clock and internal time base
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned TICK_MS      = 10;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICKS_PER_S  = 1000 / TICK_MS;

  // horn hold time in seconds
  localparam int unsigned HORN_MAX_S   = 1000;
  localparam int unsigned HORN_DFLT_S  = 180;
  localparam int unsigned HORN_W       = 10;
  localparam int unsigned HTMR_W       = 17;

  // alarm led flash half period
  localparam int unsigned FLASH_HALF_MS = 500;
  localparam int unsigned FLASH_TICKS   = FLASH_HALF_MS / TICK_MS;

  // limit encoding: percent values are hundredths of a percent of rated
  localparam int unsigned PCT_FULL     = 10000;
  localparam int unsigned PCT_EXAMPLE  = 8000;
  localparam int unsigned VAL_W        = 16;
  localparam int unsigned DLY_W        = 16;

  // remote acknowledge input synchroniser depth
  localparam int unsigned SYNC_DEPTH   = 3;

  // alarm classes; only B..F drive the horn and the flashing led
  typedef enum logic [2:0] {
    CLS_A    = 3'h0,
    CLS_B    = 3'h1,
    CLS_C    = 3'h2,
    CLS_D    = 3'h3,
    CLS_E    = 3'h4,
    CLS_F    = 3'h5,
    CLS_CTRL = 3'h6
  } aha_class_t;

  // remote acknowledge filter states
  typedef enum logic [3:0] {
    ACK_IDLE = 4'h1,
    ACK_ON   = 4'h2,
    ACK_HELD = 4'h4,
    ACK_OFF  = 4'h8
  } aha_ack_st_t;

  // configuration of one limit monitor
  typedef struct packed {
    logic             enable;
    logic             overrun;
    logic             lockable;
    logic             selfAck;
    aha_class_t       almClass;
    logic [VAL_W-1:0] limit;
    logic [VAL_W-1:0] hyst;
    logic [DLY_W-1:0] delayTicks;
  } aha_mon_cfg_t;

endpackage

// >>> core/aha_alarm_horn.sv
// module: limit monitors, horn, flashing alarm led and acknowledge handling
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// RULE1 - a new class B..F alarm starts led flashing and turns the horn on
// RULE2 - horn turns off after hold time, 0 to 1000 s, default 180 s
// RULE3 - led flashes until acknowledged by button, logic equation or interface
// RULE4 - hold time zero keeps horn on until an acknowledge
// RULE5 - remote acknowledge needs two pulses; the first silences the horn
// RULE6 - second remote pulse clears inactive alarms, keeps active ones
// RULE7 - remote pulse counts only if high for at least the on-delay
// RULE8 - input must stay low for the off-delay before next high is taken
// RULE9 - lock input suspends lockable monitors; they resume when it drops
// RULE10 - percent limits are hundredths of a percent, 8000 means 80.00 percent
// RULE11 - analog limits are integers in the input's display resolution
// RULE12 - monitors trip on under or overrun after delay, release past hysteresis
// RULE13 - self acknowledging alarms clear when the fault is gone
module aha_alarm_horn #(
  parameter int unsigned NUM_MON     = 4,
  parameter int unsigned TICK_CYCLES = aha_pkg::TICK_CYCLES
) (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic [aha_pkg::HORN_W-1:0]  hornHoldSec,
  input  wire logic [aha_pkg::DLY_W-1:0]   ackOnTicks,
  input  wire logic [aha_pkg::DLY_W-1:0]   ackOffTicks,
  input  wire logic                        remoteAckPin,
  input  wire logic                        ackButton,
  input  wire logic                        ackIface,
  input  wire logic                        lockMon,
  input  wire aha_pkg::aha_mon_cfg_t       monCfg [NUM_MON],
  input  wire logic [aha_pkg::VAL_W-1:0]   monValue [NUM_MON],
  output logic                             hornOut,
  output logic                             alarmLedOut,
  output logic [NUM_MON-1:0]               alarmActive,
  output logic [NUM_MON-1:0]               alarmStored,
  output logic [NUM_MON-1:0]               alarmUnacked
);
  import aha_pkg::*;

  localparam int unsigned TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [7:0] FLASH_LAST = 8'(FLASH_TICKS - 1);
  localparam logic [HTMR_W-1:0] TPS = HTMR_W'(TICKS_PER_S);
  localparam logic [HORN_W-1:0] HMAX = HORN_W'(HORN_MAX_S);

  // refuse settings the logic cannot serve, at elaboration
  if (NUM_MON < 1 || NUM_MON > 32)
  begin : gBadMon
    $error("NUM_MON must be 1 to 32");
  end
  if (TICK_CYCLES < 2)
  begin : gBadTick
    $error("TICK_CYCLES must be at least 2");
  end

  // whole state of the block
  typedef struct packed {
    logic [TW-1:0]                 tickCnt;
    logic [SYNC_DEPTH-1:0]         sync;
    logic                          ackLvl;
    aha_ack_st_t                   ackSt;
    logic [DLY_W-1:0]              ackCnt;
    logic                          ackSecond;
    logic                          horn;
    logic [HTMR_W-1:0]             hornTmr;
    logic                          led;
    logic [7:0]                    flashCnt;
    logic [NUM_MON-1:0]            active;
    logic [NUM_MON-1:0]            stored;
    logic [NUM_MON-1:0]            unacked;
    logic [NUM_MON-1:0][DLY_W-1:0] dly;
  } aha_state_t;

  aha_state_t s_q;
  aha_state_t s_d;

  logic [NUM_MON-1:0] violate;
  logic [NUM_MON-1:0] release_;

  // per monitor limit compare; limit and value share one integer encoding
  genvar g;
  generate
    for (g = 0; g < NUM_MON; g = g + 1)
    begin : gMon
      logic [VAL_W:0] val;
      logic [VAL_W:0] lim;
      logic [VAL_W:0] hys;
      assign val = {1'b0, monValue[g]}; // see RULE10 see RULE11
      assign lim = {1'b0, monCfg[g].limit};
      assign hys = {1'b0, monCfg[g].hyst};
      // overrun trips above, underrun below; release needs hysteresis margin
      assign violate[g] = monCfg[g].overrun ? (val > lim) : (val < lim); // see RULE12
      assign release_[g] = monCfg[g].overrun ? (val + hys < lim)
                                             : (val > lim + hys); // see RULE12
    end
  endgenerate

  logic               tick;
  logic               accept;
  logic               silence;
  logic               ackAll;
  logic               hornEvent;
  logic               suspended;
  logic               hornB2F;
  logic [HORN_W-1:0]  holdSec;
  logic [HTMR_W-1:0]  holdTicks;

  // next state of the whole block
  always_comb
  begin
    s_d       = s_q;
    accept    = 1'b0;
    silence   = 1'b0;
    ackAll    = 1'b0;
    hornEvent = 1'b0;
    suspended = 1'b0;
    hornB2F   = 1'b0;

    // 10 ms time base
    tick = (s_q.tickCnt == TICK_LAST);
    s_d.tickCnt = tick ? '0 : s_q.tickCnt + 1'b1;

    // remote acknowledge pin: change taken once last two stages agree
    s_d.sync = {s_q.sync[SYNC_DEPTH-2:0], remoteAckPin};
    if (s_q.sync[2] == s_q.sync[1])
      s_d.ackLvl = s_q.sync[2];

    // remote pulse filter with on-delay and off-delay
    case (s_q.ackSt)
      ACK_IDLE:
      begin
        s_d.ackCnt = '0;
        if (s_q.ackLvl)
          s_d.ackSt = ACK_ON;
      end
      ACK_ON:
      begin
        if (!s_q.ackLvl)
          s_d.ackSt = ACK_IDLE; // see RULE7
        else if (s_q.ackCnt >= ackOnTicks)
        begin
          accept    = 1'b1; // see RULE7
          s_d.ackSt = ACK_HELD;
        end
        else if (tick)
          s_d.ackCnt = s_q.ackCnt + 1'b1;
      end
      ACK_HELD:
      begin
        s_d.ackCnt = '0;
        if (!s_q.ackLvl)
          s_d.ackSt = ACK_OFF;
      end
      ACK_OFF:
      begin
        if (s_q.ackLvl)
          s_d.ackSt = ACK_HELD; // see RULE8
        else if (s_q.ackCnt >= ackOffTicks)
          s_d.ackSt = ACK_IDLE; // see RULE8
        else if (tick)
          s_d.ackCnt = s_q.ackCnt + 1'b1;
      end
      default:
      begin
        s_d.ackSt  = ACK_IDLE;
        s_d.ackCnt = '0;
      end
    endcase

    // first accepted pulse silences, second acknowledges everything
    if (accept)
    begin
      if (!s_q.ackSecond)
      begin
        silence       = 1'b1; // see RULE5
        s_d.ackSecond = 1'b1;
      end
      else
      begin
        ackAll        = 1'b1; // see RULE6
        s_d.ackSecond = 1'b0;
      end
    end
    if (ackButton || ackIface)
    begin
      ackAll        = 1'b1; // see RULE3
      s_d.ackSecond = 1'b0;
    end
    if (ackAll)
      silence = 1'b1;

    // limit monitors, stored messages and acknowledge flags
    for (int i = 0; i < NUM_MON; i++)
    begin
      suspended = !monCfg[i].enable || (lockMon && monCfg[i].lockable); // see RULE9
      hornB2F = (monCfg[i].almClass >= CLS_B) && (monCfg[i].almClass <= CLS_F);
      if (suspended)
      begin
        s_d.active[i] = 1'b0; // see RULE9
        s_d.dly[i]    = '0;
      end
      else if (!s_q.active[i])
      begin
        if (!violate[i])
          s_d.dly[i] = '0;
        else if (s_q.dly[i] >= monCfg[i].delayTicks)
          s_d.active[i] = 1'b1; // see RULE12
        else if (tick)
          s_d.dly[i] = s_q.dly[i] + 1'b1;
      end
      else if (release_[i])
      begin
        s_d.active[i] = 1'b0; // see RULE12
        s_d.dly[i]    = '0;
      end

      // clears first so that a new alarm in the same cycle wins
      if (ackAll)
      begin
        s_d.unacked[i] = 1'b0;
        if (!s_d.active[i])
          s_d.stored[i] = 1'b0; // see RULE6
      end
      if (monCfg[i].selfAck && !s_d.active[i])
      begin
        s_d.stored[i]  = 1'b0; // see RULE13
        s_d.unacked[i] = 1'b0; // see RULE13
      end
      if (s_d.active[i] && !s_q.active[i])
      begin
        s_d.stored[i] = 1'b1;
        if (hornB2F)
        begin
          s_d.unacked[i] = 1'b1; // see RULE1
          hornEvent      = 1'b1; // see RULE1
        end
      end
    end

    // horn with hold time; zero hold means wait for an acknowledge
    holdSec   = (hornHoldSec > HMAX) ? HMAX : hornHoldSec;
    holdTicks = HTMR_W'({{(HTMR_W-HORN_W){1'b0}}, holdSec} * TPS);
    if (hornEvent)
    begin
      s_d.horn      = 1'b1; // see RULE1
      s_d.hornTmr   = holdTicks;
      s_d.ackSecond = 1'b0;
    end
    else if (silence)
      s_d.horn = 1'b0; // see RULE4 see RULE5
    else if (s_q.horn && holdSec != '0 && tick)
    begin
      if (s_q.hornTmr <= 1)
        s_d.horn = 1'b0; // see RULE2
      else
        s_d.hornTmr = s_q.hornTmr - 1'b1;
    end

    // led flashes while any class B..F alarm is unacknowledged
    if (s_d.unacked == '0)
    begin
      s_d.led      = 1'b0; // see RULE3
      s_d.flashCnt = '0;
    end
    else if (hornEvent)
    begin
      // every new class B..F alarm restarts the flash with the led on
      s_d.led      = 1'b1; // see RULE1
      s_d.flashCnt = '0;
    end
    else if (tick)
    begin
      if (s_q.flashCnt >= FLASH_LAST)
      begin
        s_d.led      = !s_q.led;
        s_d.flashCnt = '0;
      end
      else
        s_d.flashCnt = s_q.flashCnt + 1'b1;
    end
  end

  // state register with synchronous reset
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s_q       <= '0;
      s_q.ackSt <= ACK_IDLE;
    end
    else
      s_q <= s_d;
  end

  // outputs straight from the state register
  assign hornOut      = s_q.horn;
  assign alarmLedOut  = s_q.led;
  assign alarmActive  = s_q.active;
  assign alarmStored  = s_q.stored;
  assign alarmUnacked = s_q.unacked;

endmodule
`default_nettype wire

// >>> verification/aha_alarm_horn_props.sv
// checker: timing relations of horn, led and alarm outputs
`timescale 1ns/10ps
`default_nettype none
module aha_alarm_horn_props #(
  parameter int unsigned NUM_MON     = 4,
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic                  clk,
  input wire logic                  rstn,
  input wire logic                  ackButton,
  input wire logic                  ackIface,
  input wire logic                  lockMon,
  input wire aha_pkg::aha_mon_cfg_t monCfg [NUM_MON],
  input wire logic                  hornOut,
  input wire logic                  alarmLedOut,
  input wire logic [NUM_MON-1:0]    alarmActive,
  input wire logic [NUM_MON-1:0]    alarmStored,
  input wire logic [NUM_MON-1:0]    alarmUnacked
);
  import aha_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // acknowledge from button or interface
  logic anyAck;
  assign anyAck = ackButton | ackIface;
  AST_NEW_HORN:
    assert property (|(alarmUnacked & ~$past(alarmUnacked)) |-> hornOut && alarmLedOut)
    else $error("new alarm without horn or led");
  AST_HORN_CAUSE:
    assert property ($rose(hornOut) |-> |(alarmActive & ~$past(alarmActive) & alarmUnacked))
    else $error("horn rose without new alarm");
  AST_ACK_HORN:
    assert property (anyAck |=> !hornOut || |(alarmActive & ~$past(alarmActive) & alarmUnacked))
    else $error("horn kept after acknowledge");
  AST_ACK_CLEAR:
    assert property (anyAck |=> (alarmUnacked & ~(alarmActive & ~$past(alarmActive))) == '0)
    else $error("alarm still unacked after acknowledge");
  AST_LED_IDLE:
    assert property (alarmUnacked == '0 |-> !alarmLedOut)
    else $error("led on with nothing unacked");
  AST_ACTIVE_KEPT:
    assert property ((alarmActive & ~alarmStored) == '0 && (alarmUnacked & ~alarmStored) == '0)
    else $error("active or unacked alarm not stored");
  AST_LOCK:
    assert property (lockMon && monCfg[0].lockable |=> !alarmActive[0])
    else $error("locked monitor active");
  AST_OFF:
    assert property (!monCfg[0].enable |=> !alarmActive[0])
    else $error("disabled monitor active");
  AST_SELF_ACK:
    assert property (monCfg[1].selfAck && $fell(alarmActive[1]) |-> !alarmStored[1] && !alarmUnacked[1])
    else $error("self ack alarm kept");
endmodule
`default_nettype wire

// >>> verification/aha_remote_src.sv
// partner: remote acknowledge contact on the discrete input
`timescale 1ns/10ps
`default_nettype none
module aha_remote_src (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] hiCyc,
  output logic            remoteAckPin
);
  logic [7:0] cnt = 8'h00;
  // contact closes for hiCyc cycles per request, open (low) otherwise
  always @(posedge clk)
  begin
    if (go)
      cnt <= hiCyc;
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
  end
  assign remoteAckPin = (cnt != 8'h00);
endmodule
`default_nettype wire

// >>> verification/tb.sv
// testbench: alarm horn and acknowledge block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import aha_pkg::*;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic [HORN_W-1:0] hold = '0;
  logic [DLY_W-1:0]  onT = 16'h0002;
  logic [DLY_W-1:0]  offT = 16'h0002;
  logic              btn = 1'b0;
  logic              ifc = 1'b0;
  logic              lock = 1'b0;
  logic              go = 1'b0;
  logic [7:0]        hiCyc = 8'h00;
  aha_mon_cfg_t      cfg [2];
  logic [VAL_W-1:0]  val [2];
  logic              pin;
  logic              horn;
  logic              led;
  logic [1:0]        act;
  logic [1:0]        sto;
  logic [1:0]        una;
  int                n_mismatch = 0;
  int                tests_run = 0;
  int                k;
  aha_remote_src src_u (.clk(clk), .go(go), .hiCyc(hiCyc), .remoteAckPin(pin));
  aha_alarm_horn #(.NUM_MON(2), .TICK_CYCLES(4)) dut_u (.clk(clk), .rstn(rstn), .hornHoldSec(hold),
    .ackOnTicks(onT), .ackOffTicks(offT), .remoteAckPin(pin), .ackButton(btn), .ackIface(ifc),
    .lockMon(lock), .monCfg(cfg), .monValue(val), .hornOut(horn), .alarmLedOut(led),
    .alarmActive(act), .alarmStored(sto), .alarmUnacked(una));
  // clock
  initial
  begin
    forever #5 clk = ~clk;
  end
  // verdict and end of run
  task automatic wrap_up();
    if (n_mismatch == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // wait until horn (s=0) or monitor s-1 reaches v
  task automatic wt(input int s, input logic v, input int lim);
    for (k = 0; k < lim; k++)
    begin
      cyc(1);
      if ((s == 0 ? horn : act[s-1]) === v)
        return;
    end
    n_mismatch++;
    $display("[FAIL] %0t wait timed out", $time);
    wrap_up();
  endtask
  task automatic setv(input int i, input logic [15:0] v);
    @(posedge clk);
    val[i] <= v;
  endtask
  task automatic setm(input int i, input logic o, lk, sa, input aha_class_t c, input logic [15:0] lim, v);
    @(posedge clk);
    cfg[i] <= '{1'b1, o, lk, sa, c, lim, 16'h000A, 16'h0002};
    val[i] <= v;
  endtask
  // one-cycle acknowledge from button or interface
  task automatic ack(input logic viaIf);
    @(posedge clk);
    btn <= !viaIf;
    ifc <= viaIf;
    @(posedge clk);
    btn <= 1'b0;
    ifc <= 1'b0;
    #1;
  endtask
  // remote contact pulse, then low long past the off-delay
  task automatic remote(input logic [7:0] hi);
    @(posedge clk);
    go <= 1'b1;
    hiCyc <= hi;
    @(posedge clk);
    go <= 1'b0;
    cyc(int'(hi) + 40);
  endtask
  // main sequence
  initial
  begin
    cfg[0] = '0;
    cfg[1] = '0;
    val[0] = '0;
    val[1] = '0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    cyc(3);
    chk({horn, led, una}, 4'h0);
    setm(0, 1'b1, 1'b0, 1'b0, CLS_B, 16'h1F40, 16'h2000);
    cyc(2);
    chk({2'h0, act}, 4'h0);
    wt(1, 1'b1, 40);
    chk({horn, led, una}, 4'hD);
    cyc(100);
    chk({3'h0, led}, 4'h1);
    cyc(200);
    chk({3'h0, led}, 4'h0);
    cyc(300);
    chk({3'h0, horn}, 4'h1);
    setv(0, 16'h1F3B);
    cyc(30);
    chk({2'h0, act}, 4'h1);
    setv(0, 16'h1F00);
    wt(1, 1'b0, 10);
    ack(1'b1);
    chk({horn, led, sto}, 4'h0);
    @(posedge clk);
    hold <= 10'h001;
    setv(0, 16'h2000);
    wt(1, 1'b1, 40);
    cyc(380);
    chk({3'h0, horn}, 4'h1);
    wt(0, 1'b0, 60);
    ack(1'b0);
    @(posedge clk);
    hold <= '0;
    setm(1, 1'b0, 1'b0, 1'b0, CLS_C, 16'h01A9, 16'h0100);
    wt(2, 1'b1, 40);
    remote(8'h03);
    chk({3'h0, horn}, 4'h1);
    remote(8'h1E);
    chk({1'b0, horn, una}, 4'h2);
    setv(1, 16'h0200);
    wt(2, 1'b0, 10);
    remote(8'h1E);
    chk({una, sto}, 4'h1);
    setm(0, 1'b1, 1'b1, 1'b0, CLS_D, 16'h1F40, 16'h1F00);
    wt(1, 1'b0, 10);
    @(posedge clk);
    lock <= 1'b1;
    setv(0, 16'h2000);
    cyc(30);
    chk({3'h0, act[0]}, 4'h0);
    @(posedge clk);
    lock <= 1'b0;
    wt(1, 1'b1, 40);
    setm(1, 1'b0, 1'b0, 1'b1, CLS_E, 16'h01A9, 16'h0100);
    wt(2, 1'b1, 40);
    setv(1, 16'h0200);
    wt(2, 1'b0, 10);
    chk({2'h0, sto[1], una[1]}, 4'h0);
    cyc(5);
    wrap_up();
  end
endmodule
bind aha_alarm_horn aha_alarm_horn_props #(.NUM_MON(NUM_MON), .TICK_CYCLES(TICK_CYCLES)) prop_u (
  .clk(clk), .rstn(rstn), .ackButton(ackButton), .ackIface(ackIface), .lockMon(lockMon),
  .monCfg(monCfg), .hornOut(hornOut), .alarmLedOut(alarmLedOut), .alarmActive(alarmActive),
  .alarmStored(alarmStored), .alarmUnacked(alarmUnacked));
`default_nettype wire
